// >>> core/frt_pkg.sv
// constants of the free-running timer with capture
package frt_pkg;
    // register byte addresses, one 32-bit word each, data in bits 7:0
    localparam logic [5:0] FRT_OFF_CTL_ONE   = 6'h00;
    localparam logic [5:0] FRT_OFF_CTL_TWO   = 6'h04;
    localparam logic [5:0] FRT_OFF_FLAGS     = 6'h08;
    localparam logic [5:0] FRT_OFF_CNT_MSB   = 6'h0C;
    localparam logic [5:0] FRT_OFF_CNT_LSB   = 6'h10;
    localparam logic [5:0] FRT_OFF_SH_MSB    = 6'h14;
    localparam logic [5:0] FRT_OFF_SH_LSB    = 6'h18;
    localparam logic [5:0] FRT_OFF_CAP0_MSB  = 6'h1C;
    localparam logic [5:0] FRT_OFF_CAP0_LSB  = 6'h20;
    localparam logic [5:0] FRT_OFF_CAP1_MSB  = 6'h24;
    localparam logic [5:0] FRT_OFF_CAP1_LSB  = 6'h28;
    localparam logic [5:0] FRT_OFF_PINS      = 6'h2C;
    // timer_control_one fields
    localparam int FRT_C1_CAP_IRQ_EN  = 7;
    localparam int FRT_C1_OVF_IRQ_EN  = 5;
    localparam int FRT_C1_CAP0_EDGE   = 1;
    // timer_control_two fields
    localparam int FRT_C2_SRC_LO      = 0;
    localparam int FRT_C2_SRC_HI      = 1;
    localparam int FRT_C2_EXT_EDGE    = 2;
    localparam int FRT_C2_CAP1_EDGE   = 3;
    localparam int FRT_C2_SINGLE      = 4;
    localparam int FRT_C2_PWM         = 5;
    // timer_flags_reg fields
    localparam int FRT_F_CAP0         = 7;
    localparam int FRT_F_CAP1         = 6;
    localparam int FRT_F_OVF          = 5;
    // tick source encodings
    localparam logic [1:0] FRT_SRC_DIV4 = 2'h0;
    localparam logic [1:0] FRT_SRC_DIV2 = 2'h1;
    localparam logic [1:0] FRT_SRC_DIV8 = 2'h2;
    localparam logic [1:0] FRT_SRC_EXT  = 2'h3;
    // divider masks: tick when all masked bits are one
    localparam logic [2:0] FRT_DIV2_MASK = 3'h1;
    localparam logic [2:0] FRT_DIV4_MASK = 3'h3;
    localparam logic [2:0] FRT_DIV8_MASK = 3'h7;
    // counter values
    localparam logic [15:0] FRT_CNT_RELOAD = 16'hFFFC;
    localparam logic [15:0] FRT_CNT_TOP    = 16'hFFFF;
    localparam logic [7:0]  FRT_CTL_RESET  = 8'h00;
endpackage

// >>> core/frt_timer.sv
// free-running 16-bit timer with two capture channels, Avalon-MM slave
`timescale 1ns/1ps
module frt_timer
    import frt_pkg::*;
#(
    parameter int         CNT_W      = 16,
    parameter logic [2:0] BONDED_MSK = 3'h7
) (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        arst_n,
    // avalon-mm slave
    input  wire logic [5:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // cpu side
    input  wire logic        cpu_irq_mask,
    input  wire logic        halt_mode,
    output logic             timer_irq,
    // pins
    input  wire logic [1:0]  capture_pin,
    input  wire logic        ext_tick_pin
);
    if (CNT_W != 16) begin : g_chk
        $error("frt_timer serves a 16-bit counter only");
    end

    typedef struct packed {
        logic [2:0]       sync1;
        logic [2:0]       sync2;
        logic [2:0]       sync3;
        logic [2:0]       div;
        logic [15:0]      count;
        logic [7:0]       snap_lsb;
        logic [7:0]       cnt_buf;
        logic             cnt_latched;
        logic [7:0]       sh_buf;
        logic             sh_latched;
        logic [7:0]       ctl_one;
        logic [7:0]       ctl_two;
        logic             ovf_flag;
        logic             ovf_armed;
        logic [1:0]       cap_flag;
        logic [1:0]       cap_armed;
        logic [1:0]       cap_hold;
        logic [1:0][15:0] cap_val;
        logic             ack;
        logic [31:0]      rdata;
    } frt_state_t;

    frt_state_t st_reg;
    frt_state_t st_next;

    function automatic logic hit(input logic [5:0] addr, input logic [5:0] off);
        hit = (addr[5:2] == off[5:2]);
    endfunction

    function automatic logic edge_of(input logic prev, input logic cur, input logic rise);
        edge_of = rise ? (cur & ~prev) : (prev & ~cur);
    endfunction

    logic       req;
    logic       fill;
    logic       done_rd;
    logic       done_wr;
    logic       tick;
    logic       force_cnt;
    logic [1:0] cap_edge;
    logic [1:0] cap_take;
    logic       lsb_cnt_acc;
    logic       lsb_sh_acc;
    logic [1:0] lsb_cap_acc;
    logic [1:0] msb_cap_rd;
    logic [2:0] pin_read;
    logic [2:0] div_mask;
    logic       waveform_mode;

    assign req     = avs_read | avs_write;
    assign fill    = req & ~st_reg.ack;
    assign done_rd = avs_read & st_reg.ack;
    assign done_wr = avs_write & ~avs_read & st_reg.ack;

    // one wait state: readdata is registered during the first cycle
    assign avs_waitrequest = req & ~st_reg.ack;
    assign avs_readdata    = st_reg.rdata;

    assign lsb_cnt_acc = (done_rd | done_wr) & hit(avs_address, FRT_OFF_CNT_LSB);
    assign lsb_sh_acc  = (done_rd | done_wr) & hit(avs_address, FRT_OFF_SH_LSB);
    assign lsb_cap_acc = {(done_rd | done_wr) & hit(avs_address, FRT_OFF_CAP1_LSB),
                          (done_rd | done_wr) & hit(avs_address, FRT_OFF_CAP0_LSB)};
    assign msb_cap_rd  = {done_rd & hit(avs_address, FRT_OFF_CAP1_MSB),
                          done_rd & hit(avs_address, FRT_OFF_CAP0_MSB)};
    // byte lane 0 carries the register, so a write needs it enabled
    assign force_cnt   = done_wr & avs_byteenable[0] &
                         (hit(avs_address, FRT_OFF_CNT_LSB) |
                          hit(avs_address, FRT_OFF_SH_LSB));

    always_comb begin
        case (st_reg.ctl_two[FRT_C2_SRC_HI:FRT_C2_SRC_LO])
            FRT_SRC_DIV2: div_mask = FRT_DIV2_MASK;
            FRT_SRC_DIV8: div_mask = FRT_DIV8_MASK;
            default:      div_mask = FRT_DIV4_MASK;
        endcase
    end

    // ext pin relies on edges spaced two or more clocks apart
    assign tick = ~halt_mode &
        ((st_reg.ctl_two[FRT_C2_SRC_HI:FRT_C2_SRC_LO] == FRT_SRC_EXT) ?
         edge_of(st_reg.sync3[2], st_reg.sync2[2], st_reg.ctl_two[FRT_C2_EXT_EDGE]) :
         ((st_reg.div & div_mask) == div_mask));

    assign waveform_mode = st_reg.ctl_two[FRT_C2_SINGLE] | st_reg.ctl_two[FRT_C2_PWM];

    // pin 1 always feeds capture; pin 0 capture is blocked in single pulse or pwm mode
    assign cap_edge[0] = edge_of(st_reg.sync3[0], st_reg.sync2[0],
                                 st_reg.ctl_one[FRT_C1_CAP0_EDGE]);
    assign cap_edge[1] = edge_of(st_reg.sync3[1], st_reg.sync2[1],
                                 st_reg.ctl_two[FRT_C2_CAP1_EDGE]);
    assign cap_take[0] = cap_edge[0] & ~st_reg.cap_hold[0] & ~waveform_mode;
    assign cap_take[1] = cap_edge[1] & ~st_reg.cap_hold[1];

    // synchronised pin levels; unbonded inputs always read one
    assign pin_read = st_reg.sync2 | ~BONDED_MSK;

    always_comb begin
        st_next = st_reg;
        st_next.sync1 = {ext_tick_pin, capture_pin};
        st_next.sync2 = st_reg.sync1;
        st_next.sync3 = st_reg.sync2;
        st_next.ack   = fill;

        if (!halt_mode) begin
            st_next.div = st_reg.div + 3'h1;
        end
        if (force_cnt) begin
            st_next.count = FRT_CNT_RELOAD;
        end else if (tick) begin
            st_next.count = st_reg.count + 16'h0001;
        end

        // flags: arm on a flags read that saw them, clear on low access
        if (done_rd && hit(avs_address, FRT_OFF_FLAGS)) begin
            st_next.ovf_armed = st_reg.rdata[FRT_F_OVF];
            st_next.cap_armed = {st_reg.rdata[FRT_F_CAP1], st_reg.rdata[FRT_F_CAP0]};
        end
        if (lsb_cnt_acc && st_reg.ovf_armed) begin
            st_next.ovf_flag  = 1'b0;
            st_next.ovf_armed = 1'b0;
        end
        // set wins over a clear in the same cycle
        if (tick && !force_cnt && st_reg.count == FRT_CNT_TOP) begin
            st_next.ovf_flag = 1'b1;
        end

        for (int i = 0; i < 2; i++) begin
            if (lsb_cap_acc[i] && st_reg.cap_armed[i]) begin
                st_next.cap_flag[i]  = 1'b0;
                st_next.cap_armed[i] = 1'b0;
            end
            if (msb_cap_rd[i]) begin
                st_next.cap_hold[i] = 1'b1;
            end
            if (lsb_cap_acc[i] && avs_read) begin
                st_next.cap_hold[i] = 1'b0;
            end
            if (cap_take[i]) begin
                st_next.cap_val[i]  = st_reg.count;
                st_next.cap_flag[i] = 1'b1;
            end
        end

        // paired reads: high read latches low byte from the same snapshot
        if (done_rd && hit(avs_address, FRT_OFF_CNT_MSB) && !st_reg.cnt_latched) begin
            st_next.cnt_buf     = st_reg.snap_lsb;
            st_next.cnt_latched = 1'b1;
        end
        if (done_rd && hit(avs_address, FRT_OFF_SH_MSB) && !st_reg.sh_latched) begin
            st_next.sh_buf     = st_reg.snap_lsb;
            st_next.sh_latched = 1'b1;
        end
        if (done_rd && hit(avs_address, FRT_OFF_CNT_LSB)) begin
            st_next.cnt_latched = 1'b0;
        end
        if (done_rd && hit(avs_address, FRT_OFF_SH_LSB)) begin
            st_next.sh_latched = 1'b0;
        end

        if (done_wr && avs_byteenable[0]) begin
            if (hit(avs_address, FRT_OFF_CTL_ONE)) begin
                st_next.ctl_one = avs_writedata[7:0];
            end
            if (hit(avs_address, FRT_OFF_CTL_TWO)) begin
                st_next.ctl_two = avs_writedata[7:0];
            end
        end

        // read data registered in the first cycle of a request
        if (fill) begin
            st_next.snap_lsb = st_reg.count[7:0];
            st_next.rdata    = 32'h0000_0000;
            if (avs_read) begin
                case (avs_address[5:2])
                    FRT_OFF_CTL_ONE[5:2]:  st_next.rdata[7:0] = st_reg.ctl_one;
                    FRT_OFF_CTL_TWO[5:2]:  st_next.rdata[7:0] = st_reg.ctl_two;
                    FRT_OFF_FLAGS[5:2]: begin
                        st_next.rdata[FRT_F_CAP0] = st_reg.cap_flag[0];
                        st_next.rdata[FRT_F_CAP1] = st_reg.cap_flag[1];
                        st_next.rdata[FRT_F_OVF]  = st_reg.ovf_flag;
                    end
                    FRT_OFF_CNT_MSB[5:2],
                    FRT_OFF_SH_MSB[5:2]:   st_next.rdata[7:0] = st_reg.count[15:8];
                    FRT_OFF_CNT_LSB[5:2]:  st_next.rdata[7:0] = st_reg.cnt_latched ?
                                               st_reg.cnt_buf : st_reg.count[7:0];
                    FRT_OFF_SH_LSB[5:2]:   st_next.rdata[7:0] = st_reg.sh_latched ?
                                               st_reg.sh_buf : st_reg.count[7:0];
                    FRT_OFF_CAP0_MSB[5:2]: st_next.rdata[7:0] = st_reg.cap_val[0][15:8];
                    FRT_OFF_CAP0_LSB[5:2]: st_next.rdata[7:0] = st_reg.cap_val[0][7:0];
                    FRT_OFF_CAP1_MSB[5:2]: st_next.rdata[7:0] = st_reg.cap_val[1][15:8];
                    FRT_OFF_CAP1_LSB[5:2]: st_next.rdata[7:0] = st_reg.cap_val[1][7:0];
                    FRT_OFF_PINS[5:2]:     st_next.rdata[2:0] = pin_read;
                    default:               st_next.rdata = 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg         <= '0;
            st_reg.count   <= FRT_CNT_RELOAD;
            st_reg.ctl_one <= FRT_CTL_RESET;
            st_reg.ctl_two <= FRT_CTL_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // pending requests stay until enable and cpu mask allow them
    assign timer_irq = ~cpu_irq_mask &
        ((st_reg.ovf_flag & st_reg.ctl_one[FRT_C1_OVF_IRQ_EN]) |
         ((|st_reg.cap_flag) & st_reg.ctl_one[FRT_C1_CAP_IRQ_EN]));

    // checks
    sequence s_cnt_msb_rd;
        done_rd && hit(avs_address, FRT_OFF_CNT_MSB) && !st_reg.cnt_latched;
    endsequence

    sequence s_cnt_lsb_rd;
        done_rd && hit(avs_address, FRT_OFF_CNT_LSB) && st_reg.cnt_latched;
    endsequence

    sequence s_cap0_held;
        st_reg.cap_hold[0] && !lsb_cap_acc[0];
    endsequence

    // latch holds the low byte as it was when the high byte request began
    property p_msb_latch;
        @(posedge sys_clk) disable iff (!arst_n)
        s_cnt_msb_rd |=> st_reg.cnt_latched &&
                         st_reg.cnt_buf == $past(st_reg.count[7:0], 2);
    endproperty

    property p_paired_read;
        @(posedge sys_clk) disable iff (!arst_n)
        s_cnt_lsb_rd |-> st_reg.rdata[7:0] == st_reg.cnt_buf;
    endproperty

    AST_MSB_LATCH: assert property (p_msb_latch)
        else $error("high byte read did not latch the low byte");

    AST_PAIRED_READ: assert property (p_paired_read)
        else $error("low byte read after high read did not return latched byte");

    AST_FORCE_RELOAD: assert property (@(posedge sys_clk) disable iff (!arst_n)
        force_cnt |=> st_reg.count == FRT_CNT_RELOAD)
        else $error("low byte write did not reload counter");

    AST_COUNT_STEP: assert property (@(posedge sys_clk) disable iff (!arst_n)
        tick && !force_cnt |=> st_reg.count == $past(st_reg.count) + 16'h0001)
        else $error("counter did not advance on tick");

    // every prescaled rate is two clocks or slower
    AST_DIV_SPACING: assert property (@(posedge sys_clk) disable iff (!arst_n)
        tick && st_reg.ctl_two[FRT_C2_SRC_HI:FRT_C2_SRC_LO] != FRT_SRC_EXT
        |=> !tick || st_reg.ctl_two[FRT_C2_SRC_HI:FRT_C2_SRC_LO] == FRT_SRC_EXT)
        else $error("prescaled tick on two clocks in a row");

    AST_EXT_QUIET: assert property (@(posedge sys_clk) disable iff (!arst_n)
        st_reg.ctl_two[FRT_C2_SRC_HI:FRT_C2_SRC_LO] == FRT_SRC_EXT &&
        st_reg.sync2[2] == st_reg.sync3[2] |-> !tick)
        else $error("external source ticked without a pin edge");

    AST_EXT_EDGE: assert property (@(posedge sys_clk) disable iff (!arst_n)
        st_reg.ctl_two[FRT_C2_SRC_HI:FRT_C2_SRC_LO] == FRT_SRC_EXT && !halt_mode &&
        st_reg.sync3[2] && !st_reg.sync2[2] |-> tick == !st_reg.ctl_two[FRT_C2_EXT_EDGE])
        else $error("external falling edge misjudged by edge select");

    AST_HALT_HOLD: assert property (@(posedge sys_clk) disable iff (!arst_n)
        halt_mode && !force_cnt |=> $stable(st_reg.count))
        else $error("counter moved in halt");

    AST_OVF_SET: assert property (@(posedge sys_clk) disable iff (!arst_n)
        tick && !force_cnt && st_reg.count == FRT_CNT_TOP
        |=> st_reg.ovf_flag && st_reg.count == 16'h0000)
        else $error("rollover did not set overflow flag");

    AST_OVF_CLEAR: assert property (@(posedge sys_clk) disable iff (!arst_n)
        $fell(st_reg.ovf_flag) |-> $past(lsb_cnt_acc) && !$past(lsb_sh_acc))
        else $error("overflow flag cleared without count low access");

    AST_OVF_ARMED: assert property (@(posedge sys_clk) disable iff (!arst_n)
        lsb_cnt_acc && !st_reg.ovf_armed && st_reg.ovf_flag |=> st_reg.ovf_flag)
        else $error("overflow flag cleared without a flags read first");

    AST_SHADOW_KEEP: assert property (@(posedge sys_clk) disable iff (!arst_n)
        lsb_sh_acc && st_reg.ovf_flag |=> st_reg.ovf_flag)
        else $error("shadow low byte access cleared overflow flag");

    AST_IRQ_LEVEL: assert property (@(posedge sys_clk) disable iff (!arst_n)
        st_reg.ovf_flag && st_reg.ctl_one[FRT_C1_OVF_IRQ_EN] && !cpu_irq_mask
        |-> timer_irq)
        else $error("overflow request not raised");

    AST_IRQ_MASKED: assert property (@(posedge sys_clk) disable iff (!arst_n)
        cpu_irq_mask |-> !timer_irq)
        else $error("timer request raised while cpu mask set");

    AST_CAP_IRQ: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (|st_reg.cap_flag) && st_reg.ctl_one[FRT_C1_CAP_IRQ_EN] && !cpu_irq_mask
        |-> timer_irq)
        else $error("capture request not raised");

    AST_CAP_LOAD: assert property (@(posedge sys_clk) disable iff (!arst_n)
        cap_take[1] |=> st_reg.cap_val[1] == $past(st_reg.count) && st_reg.cap_flag[1])
        else $error("capture did not load counter");

    AST_CAP_CLEAR: assert property (@(posedge sys_clk) disable iff (!arst_n)
        $fell(st_reg.cap_flag[0]) |-> $past(lsb_cap_acc[0]) && $past(st_reg.cap_armed[0]))
        else $error("capture flag cleared without flags read and low access");

    AST_CAP_BLOCK: assert property (@(posedge sys_clk) disable iff (!arst_n)
        s_cap0_held |=> $stable(st_reg.cap_val[0]))
        else $error("capture taken while high byte held");

    AST_CAP_NO_FLAG: assert property (@(posedge sys_clk) disable iff (!arst_n)
        s_cap0_held ##0 !st_reg.cap_flag[0] |=> !st_reg.cap_flag[0])
        else $error("capture flag set while high byte held");

    AST_WAVE_CAP0: assert property (@(posedge sys_clk) disable iff (!arst_n)
        waveform_mode |-> !cap_take[0])
        else $error("channel one captured in waveform mode");

    AST_UNBONDED_ONE: assert property (@(posedge sys_clk) disable iff (!arst_n)
        fill && avs_read && hit(avs_address, FRT_OFF_PINS)
        |=> (st_reg.rdata[2:0] & ~BONDED_MSK) == ~BONDED_MSK)
        else $error("unbonded input did not read as one");
endmodule

// >>> dv/frt_pin_src.sv
// external sources on the capture pins and the tick pin
`timescale 1ns/1ps
module frt_pin_src #(
    parameter int GAP = 8
) (
    input  wire logic  clk,
    output logic [1:0] capture_pin,
    output logic       ext_tick_pin
);
    initial begin
        capture_pin  = 2'h0;
        ext_tick_pin = 1'b0;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
    endtask
    // every level held GAP clocks, so active edges stay well apart
    task automatic set_ext(input logic v);
        ext_tick_pin <= v;
        wait_clk(GAP);
    endtask
    task automatic pulse_ext(input int n);
        repeat (n) begin
            set_ext(1'b1);
            set_ext(1'b0);
        end
    endtask
    task automatic set_cap(input int ch, input logic v);
        capture_pin[ch] <= v;
        wait_clk(GAP);
    endtask
endmodule

// >>> dv/free_running_timer_capture_tb.sv
// self-checking bench for the free-running timer with capture
`timescale 1ns/1ps
module free_running_timer_capture_tb;
    import frt_pkg::*;
    logic        sys_clk;
    logic        arst_n;
    logic [5:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        cpu_irq_mask;
    logic        halt_mode;
    logic        timer_irq;
    logic [1:0]  capture_pin;
    logic        ext_tick_pin;
    logic [7:0]  exp_q[$];
    logic [5:0]  adr_q[$];
    logic [15:0] cnt;
    logic [15:0] old;
    int          err_count;
    int          num_checks;

    // ext pin left unbonded here so its read-as-one path is exercised
    frt_timer #(.BONDED_MSK(3'h3)) uut (.sys_clk(sys_clk), .arst_n(arst_n),
        .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .cpu_irq_mask(cpu_irq_mask),
        .halt_mode(halt_mode), .timer_irq(timer_irq), .capture_pin(capture_pin),
        .ext_tick_pin(ext_tick_pin));
    frt_pin_src src (.clk(sys_clk), .capture_pin(capture_pin), .ext_tick_pin(ext_tick_pin));

    initial sys_clk = 1'b0;
    always #2.5 sys_clk = ~sys_clk;

    // values seen before this edge's updates land
    always @(posedge sys_clk) begin
        if (avs_read && avs_waitrequest === 1'b0 && exp_q.size() > 0) begin
            num_checks++;
            if (avs_readdata !== {24'h0, exp_q[0]}) begin
                $display("unexpected read at %h: expected %h, seen %h",
                         adr_q[0], exp_q[0], avs_readdata);
                err_count++;
            end
            void'(exp_q.pop_front());
            void'(adr_q.pop_front());
        end
    end

    task automatic final_report();
        $display("checks %0d, mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic [5:0] a, input logic wr, input logic [7:0] d,
                       input logic [3:0] be);
        int n;
        n = 0;
        avs_address    <= a;
        avs_write      <= wr;
        avs_read       <= ~wr;
        avs_writedata  <= {24'($urandom()), d};
        avs_byteenable <= be;
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) begin
            $display("unexpected waitrequest at %h: expected 0, seen 1", a);
            err_count++;
        end
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        adr_q.push_back(a);
        bus(a, 1'b0, 8'h00, 4'($urandom()));
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        bus(a, 1'b1, d, {3'($urandom()), 1'b1});
    endtask
    task automatic chk_irq(input logic e);
        src.wait_clk(2);
        num_checks++;
        if (timer_irq !== e) begin
            $display("unexpected timer_irq: expected %b, seen %b", e, timer_irq);
            err_count++;
        end
    endtask

    initial begin
        #200000;
        $display("unexpected hang: expected completion, seen timeout");
        err_count++;
        final_report();
    end

    initial begin
        err_count = 0; num_checks = 0;
        arst_n = 1'b0; avs_address = 6'h00; avs_read = 1'b0; avs_write = 1'b0;
        avs_writedata = 32'h0; cpu_irq_mask = 1'b0; halt_mode = 1'b1;
        avs_byteenable = 4'h0;
        void'($urandom(32'h95d5));
        repeat (8) @(posedge sys_clk);
        arst_n <= 1'b1;
        @(posedge sys_clk);
        rd(FRT_OFF_CNT_MSB, 8'hFF);
        rd(FRT_OFF_CNT_LSB, 8'hFC);
        rd(FRT_OFF_SH_MSB, 8'hFF);
        rd(FRT_OFF_SH_LSB, 8'hFC);
        rd(FRT_OFF_FLAGS, 8'h00);
        wr(6'h30, 8'($urandom()));
        rd(6'h30, 8'h00);
        // halted counter must not move even on the fastest tick
        wr(FRT_OFF_CTL_TWO, 8'(FRT_SRC_DIV2));
        wr(FRT_OFF_SH_LSB, 8'($urandom()));
        src.wait_clk(20);
        rd(FRT_OFF_CNT_MSB, 8'hFF);
        rd(FRT_OFF_CNT_LSB, 8'hFC);
        halt_mode <= 1'b0;
        src.wait_clk(40);
        rd(FRT_OFF_CNT_MSB, 8'h00);
        // low byte unknown while counting; this read only closes the pair
        bus(FRT_OFF_CNT_LSB, 1'b0, 8'h00, 4'hF);
        rd(FRT_OFF_FLAGS, 8'h20);
        wr(FRT_OFF_CTL_TWO, 8'h07);
        wr(FRT_OFF_CNT_LSB, 8'($urandom()));
        rd(FRT_OFF_FLAGS, 8'h00);
        cnt = FRT_CNT_RELOAD;
        old = 16'(4 + $urandom() % 3);
        src.pulse_ext(int'(old));
        cnt = cnt + old;
        wr(FRT_OFF_CTL_ONE, 8'h20);
        chk_irq(1'b1);
        cpu_irq_mask <= 1'b1;
        chk_irq(1'b0);
        cpu_irq_mask <= 1'b0;
        rd(FRT_OFF_CNT_MSB, cnt[15:8]);
        old = cnt;
        src.pulse_ext(1);
        cnt = cnt + 16'h1;
        rd(FRT_OFF_CNT_MSB, old[15:8]);
        rd(FRT_OFF_CNT_LSB, old[7:0]);
        rd(FRT_OFF_CNT_LSB, cnt[7:0]);
        rd(FRT_OFF_FLAGS, 8'h20);
        rd(FRT_OFF_SH_LSB, cnt[7:0]);
        rd(FRT_OFF_FLAGS, 8'h20);
        rd(FRT_OFF_CNT_LSB, cnt[7:0]);
        rd(FRT_OFF_FLAGS, 8'h00);
        chk_irq(1'b0);
        // falling edge selected: a rise alone must not count
        wr(FRT_OFF_CTL_TWO, 8'h03);
        src.set_ext(1'b1);
        rd(FRT_OFF_CNT_LSB, cnt[7:0]);
        src.set_ext(1'b0);
        cnt = cnt + 16'h1;
        rd(FRT_OFF_CNT_LSB, cnt[7:0]);
        // lane 0 off: the low byte is not written, so no reload
        bus(FRT_OFF_CNT_LSB, 1'b1, 8'h00, 4'hE);
        rd(FRT_OFF_CNT_LSB, cnt[7:0]);
        wr(FRT_OFF_CTL_ONE, 8'h82);
        src.set_cap(0, 1'b1);
        chk_irq(1'b1);
        rd(FRT_OFF_FLAGS, 8'h80);
        rd(FRT_OFF_CAP0_MSB, cnt[15:8]);
        rd(FRT_OFF_CAP0_LSB, cnt[7:0]);
        rd(FRT_OFF_FLAGS, 8'h00);
        chk_irq(1'b0);
        old = cnt;
        rd(FRT_OFF_CAP0_MSB, old[15:8]);
        src.set_cap(0, 1'b0);
        src.pulse_ext(1);
        cnt = cnt + 16'h1;
        src.set_cap(0, 1'b1);
        rd(FRT_OFF_FLAGS, 8'h00);
        rd(FRT_OFF_CAP0_LSB, old[7:0]);
        src.set_cap(0, 1'b0);
        src.pulse_ext(2);
        cnt = cnt + 16'h2;
        src.set_cap(0, 1'b1);
        rd(FRT_OFF_FLAGS, 8'h80);
        rd(FRT_OFF_CAP0_MSB, cnt[15:8]);
        rd(FRT_OFF_CAP0_LSB, cnt[7:0]);
        rd(FRT_OFF_FLAGS, 8'h00);
        // single pulse leaves only channel two capturing
        wr(FRT_OFF_CTL_TWO, 8'h13);
        src.set_cap(1, 1'b1);
        src.set_cap(0, 1'b0);
        src.pulse_ext(1);
        cnt = cnt + 16'h1;
        src.set_cap(0, 1'b1);
        src.set_cap(1, 1'b0);
        rd(FRT_OFF_FLAGS, 8'h40);
        rd(FRT_OFF_CAP1_MSB, cnt[15:8]);
        rd(FRT_OFF_CAP1_LSB, cnt[7:0]);
        rd(FRT_OFF_PINS, 8'h05);
        src.wait_clk(4);
        final_report();
    end
endmodule
